// ### css_clock_switch.sv
// Clock switch status and control block with APB register access
`timescale 1ns/100ps
`include "css_map.svh"
module css_clock_switch
#(
    parameter int ADDR_W = 8
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] RESET_SOURCE,
    input wire logic [3:0] RESET_DIVIDER,
    input wire logic EXT_READY,
    input wire logic HF_READY,
    input wire logic MF_READY,
    input wire logic LF_READY,
    input wire logic FRC_READY,
    input wire logic PLL_LOCK,
    output css_pkg::css_source_type SYS_SOURCE,
    output logic [3:0] SYS_DIVIDER,
    output logic [9:0] SYS_DIV_RATIO,
    output logic EXT_ENABLE,
    output logic HF_ENABLE,
    output logic MF_ENABLE,
    output logic LF_ENABLE,
    output logic FRC_ENABLE,
    output logic PLL_ENABLE,
    output logic IRQ
);
    import css_pkg::*;

    initial
    begin
        if (ADDR_W < 5)
            $error("ADDR_W too small for register map");
    end

    // =====================================================
    // Encoding helpers
    function automatic logic src_valid(input logic [2:0] s);
        return s == CSS_SRC_EXT || s == CSS_SRC_HF || s == CSS_SRC_LF
            || s == CSS_SRC_EXT_PLL || s == CSS_SRC_HF_PLL; // R4
    endfunction : src_valid

    function automatic logic div_valid(input logic [3:0] d);
        return d <= `CSS_DIV_MAX; // R5
    endfunction : div_valid

    function automatic logic [9:0] div_ratio(input logic [3:0] d);
        return 10'(1) << d; // R5
    endfunction : div_ratio

    // Oscillators that a source code draws on, in ready-register layout
    function automatic logic [7:0] src_needs(input logic [2:0] s);
        logic [7:0] n;
        n = '0;
        unique case (s)
            CSS_SRC_EXT: n[`CSS_RDY_EXT] = 1'b1;
            CSS_SRC_HF: n[`CSS_RDY_HF] = 1'b1;
            CSS_SRC_LF: n[`CSS_RDY_LF] = 1'b1;
            CSS_SRC_EXT_PLL:
            begin
                n[`CSS_RDY_EXT] = 1'b1;
                n[`CSS_RDY_PLL] = 1'b1;
            end
            CSS_SRC_HF_PLL:
            begin
                n[`CSS_RDY_HF] = 1'b1;
                n[`CSS_RDY_PLL] = 1'b1;
            end
            default: n = '0;
        endcase
        return n;
    endfunction : src_needs

    function automatic logic src_ready(input logic [2:0] s, input logic [7:0] r);
        return src_valid(s) && ((src_needs(s) & r) == src_needs(s));
    endfunction : src_ready

    function automatic logic is_pll(input logic [2:0] s);
        return src_needs(s)[`CSS_RDY_PLL];
    endfunction : is_pll

    css_state_type s;
    css_state_type n;

    logic [7:0] addr;
    logic hit;
    logic wr;
    logic rd_setup;
    logic in_prog;
    logic switching;
    logic pll_in_ok;
    logic [2:0] pll_src;
    logic [7:0] flags;
    logic int_set;
    logic int_clr;
    logic [2:0] w_src;
    logic [3:0] w_div;

    assign addr = 8'(PADDR);
    assign hit = addr == `CSS_OFF_REQUEST || addr == `CSS_OFF_CURRENT
        || addr == `CSS_OFF_SWITCH || addr == `CSS_OFF_READY
        || addr == `CSS_OFF_FORCE || addr == `CSS_OFF_INT_STATUS
        || addr == `CSS_OFF_INT_MASK;

    // =====================================================
    // Next-state logic
    always_comb
    begin
        n = s;
        wr = PSEL && PENABLE && PWRITE;
        rd_setup = PSEL && !PENABLE && !PWRITE;
        w_src = PWDATA[`CSS_SRC_MSB:`CSS_SRC_LSB];
        w_div = PWDATA[`CSS_DIV_MSB:`CSS_DIV_LSB];
        in_prog = {s.req_src, s.req_div} != {s.cur_src, s.cur_div};
        switching = s.started && s.new_ready && !s.hold; // R7
        // PLL input follows the running setting while it uses the PLL
        pll_src = is_pll(s.cur_src) ? s.cur_src : s.req_src;
        pll_in_ok = ((src_needs(pll_src) & s.ready) & ~8'(1))
            == (src_needs(pll_src) & ~8'(1));
        flags = s.ready;
        flags[`CSS_RDY_PLL] = s.ready[`CSS_RDY_PLL] && s.osc_en[`CSS_RDY_PLL]
            && pll_in_ok; // R11

        // Three-stage input filter: accept a level once the last two stages agree
        n.sync1 = 8'(0);
        n.sync1[`CSS_RDY_EXT] = EXT_READY;
        n.sync1[`CSS_RDY_HF] = HF_READY;
        n.sync1[`CSS_RDY_MF] = MF_READY;
        n.sync1[`CSS_RDY_LF] = LF_READY;
        n.sync1[`CSS_RDY_FRC] = FRC_READY;
        n.sync1[`CSS_RDY_PLL] = PLL_LOCK;
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;
        for (int i = 0; i < 8; i++)
        begin
            if (s.sync2[i] == s.sync3[i])
                n.ready[i] = s.sync3[i]; // R10
        end

        int_set = 1'b0;
        int_clr = 1'b0;
        if (!s.started)
        begin
            // Straps captured after release; reserved straps fall back
            n.started = 1'b1;
            if (src_valid(RESET_SOURCE) && div_valid(RESET_DIVIDER))
            begin
                n.req_src = RESET_SOURCE; // R14
                n.req_div = RESET_DIVIDER;
            end
            else
            begin
                n.req_src = `CSS_DEF_SRC; // R18
                n.req_div = `CSS_DEF_DIV;
            end
            n.cur_src = n.req_src; // R3
            n.cur_div = n.req_div; // R3
            n.cur_ratio = div_ratio(n.req_div);
            n.new_ready = 1'b0;
        end
        else
        begin
            n.new_ready = in_prog && src_ready(s.req_src, flags)
                && !switching; // R9 R15
            int_set = n.new_ready && !s.new_ready; // R16 R6
            if (switching)
            begin
                n.cur_src = s.req_src; // R15 R1
                n.cur_div = s.req_div; // R15 R2
                n.cur_ratio = div_ratio(s.req_div);
            end
            if (wr)
            begin
                unique case (addr)
                    `CSS_OFF_REQUEST:
                    begin
                        // Reserved requests leave both fields untouched
                        if (src_valid(w_src) && div_valid(w_div))
                        begin
                            n.req_src = w_src; // R18 R17
                            n.req_div = w_div;
                        end
                    end
                    `CSS_OFF_SWITCH: n.hold = PWDATA[`CSS_HOLD_BIT]; // R6
                    `CSS_OFF_FORCE: n.force_on = PWDATA[7:0] & `CSS_FORCE_MASK; // R12
                    `CSS_OFF_INT_STATUS: int_clr = PWDATA[`CSS_INT_SWITCH];
                    `CSS_OFF_INT_MASK: n.int_mask = PWDATA[`CSS_INT_SWITCH];
                    default: n.int_mask = s.int_mask;
                endcase
            end
        end

        // Set beats clear so an event during the clear write survives
        n.int_status = (s.int_status && !int_clr) || int_set;
        n.irq = n.int_status && n.int_mask;
        n.osc_en = n.force_on | src_needs(n.req_src) | src_needs(n.cur_src); // R12

        if (rd_setup)
        begin
            n.rdata = '0; // R13
            unique case (addr)
                `CSS_OFF_REQUEST:
                    n.rdata[`CSS_SRC_MSB:0] = {s.req_src, s.req_div};
                `CSS_OFF_CURRENT:
                    n.rdata[`CSS_SRC_MSB:0] = {s.cur_src, s.cur_div}; // R1 R2
                `CSS_OFF_SWITCH:
                begin
                    n.rdata[`CSS_HOLD_BIT] = s.hold;
                    n.rdata[`CSS_DONE_BIT] = !in_prog; // R8
                    n.rdata[`CSS_NEWRDY_BIT] = s.new_ready; // R9
                end
                `CSS_OFF_READY: n.rdata[7:0] = flags & `CSS_READY_MASK; // R10 R13
                `CSS_OFF_FORCE: n.rdata[7:0] = s.force_on;
                `CSS_OFF_INT_STATUS: n.rdata[`CSS_INT_SWITCH] = s.int_status;
                `CSS_OFF_INT_MASK: n.rdata[`CSS_INT_SWITCH] = s.int_mask;
                default: n.rdata = '0;
            endcase
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            s <= '0;
        else
            s <= n;
    end

    // =====================================================
    // Outputs
    assign PRDATA = s.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign SYS_SOURCE = css_source_type'(s.cur_src);
    assign SYS_DIVIDER = s.cur_div;
    assign SYS_DIV_RATIO = s.cur_ratio;
    assign EXT_ENABLE = s.osc_en[`CSS_RDY_EXT];
    assign HF_ENABLE = s.osc_en[`CSS_RDY_HF];
    assign MF_ENABLE = s.osc_en[`CSS_RDY_MF];
    assign LF_ENABLE = s.osc_en[`CSS_RDY_LF];
    assign FRC_ENABLE = s.osc_en[`CSS_RDY_FRC];
    assign PLL_ENABLE = s.osc_en[`CSS_RDY_PLL];
    assign IRQ = s.irq;

    // =====================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    a_reset_match: assert property ($rose(s.started) |-> // R3
        s.cur_src == s.req_src && s.cur_div == s.req_div)
        else $error("current differs from request after reset");

    a_switch_update: assert property (switching |=> // R7
        s.cur_src == $past(s.req_src) && s.cur_div == $past(s.req_div)
        && !s.new_ready)
        else $error("switch did not update current setting");

    a_hold_stall: assert property (s.new_ready && s.hold |=> // R6
        s.cur_src == $past(s.cur_src) && s.cur_div == $past(s.cur_div))
        else $error("held switch changed current setting");

    a_ready_irq: assert property ($rose(s.new_ready) |-> s.int_status) // R16
        else $error("new-ready rose without interrupt flag");

    a_newrdy_cause: assert property (s.new_ready |-> // R9
        $past(in_prog && src_ready(s.req_src, flags)))
        else $error("new-ready set without pending ready switch");

    a_no_reserved: assert property (s.started |-> // R18
        src_valid(s.cur_src) && div_valid(s.cur_div))
        else $error("current setting shows reserved code");

    a_ratio_decode: assert property (s.started |-> // R5
        SYS_DIV_RATIO == div_ratio(s.cur_div))
        else $error("divide ratio mismatch");

    a_force_kept: assert property ((s.osc_en & s.force_on) == s.force_on) // R12
        else $error("forced oscillator not enabled");

    a_zero_bits: assert property (PSEL && PENABLE && !PWRITE |-> // R13
        PRDATA[31:8] == '0)
        else $error("unimplemented read bits not zero");

    a_done_read: assert property (rd_setup && addr == `CSS_OFF_SWITCH |=> // R8
        s.rdata[`CSS_DONE_BIT] == ($past(s.req_src) == $past(s.cur_src)
        && $past(s.req_div) == $past(s.cur_div)))
        else $error("done flag does not reflect match");

    c_free_switch: cover property (s.new_ready && !s.hold ##1 !s.new_ready);
    c_held_switch: cover property (s.new_ready && s.hold [*3] ##1 !s.hold);
    c_abandon: cover property (s.new_ready && s.hold ##1 !s.new_ready && !switching);
    c_irq: cover property ($rose(IRQ));
endmodule : css_clock_switch

// ### css_map.svh
// Register map, field positions and reset values of the clock switch block
// Functional notes
// R1: Current register bits 6-4 report active source
// R2: Current register bits 3-0 report active divider
// R3: Reset makes current settings equal requested ones
// R4: Source codes 111,110,101,010,001; others reserved
// R5: Divider codes 0-9 divide by powers of two
// R6: Hold set suspends switch, interrupt when ready
// R7: Hold clear when ready rises performs switch
// R8: Done flag reads one when settings match
// R9: New-ready flag: switch pending and oscillator ready
// R10: Ready flags at bits 7,6,5,4,2 per oscillator
// R11: PLL ready needs enable, input ready, lock
// R12: Force-on bits 7,6,5,4,2 keep oscillators running
// R13: Unimplemented bits read as zero
// R14: Current register holds power-on settings at start
// R15: Switch updates current, sets done, clears new-ready
// R16: New-ready and switch interrupt flag set together
// R17: Software releases hold or abandons held switch
// R18: Current settings never show reserved encodings
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// =====================================================
// Register offsets
`define CSS_OFF_REQUEST 8'h00
`define CSS_OFF_CURRENT 8'h04
`define CSS_OFF_SWITCH 8'h08
`define CSS_OFF_READY 8'h0C
`define CSS_OFF_FORCE 8'h10
`define CSS_OFF_INT_STATUS 8'h14
`define CSS_OFF_INT_MASK 8'h18
// =====================================================
// Field positions
`define CSS_SRC_MSB 6
`define CSS_SRC_LSB 4
`define CSS_DIV_MSB 3
`define CSS_DIV_LSB 0
`define CSS_HOLD_BIT 7
`define CSS_DONE_BIT 4
`define CSS_NEWRDY_BIT 3
`define CSS_RDY_EXT 7
`define CSS_RDY_HF 6
`define CSS_RDY_MF 5
`define CSS_RDY_LF 4
`define CSS_RDY_FRC 2
`define CSS_RDY_PLL 0
`define CSS_READY_MASK 8'hF5
`define CSS_FORCE_MASK 8'hF4
`define CSS_INT_SWITCH 0
// =====================================================
// Values
`define CSS_DIV_MAX 4'h9
`define CSS_DEF_SRC 3'h6
`define CSS_DEF_DIV 4'h2
`endif

// ### css_pkg.sv
// Types shared by the clock switch status and control block
package css_pkg;
    typedef enum logic [2:0]
    {
        CSS_SRC_EXT = 3'b111,
        CSS_SRC_HF = 3'b110,
        CSS_SRC_LF = 3'b101,
        CSS_SRC_EXT_PLL = 3'b010,
        CSS_SRC_HF_PLL = 3'b001
    } css_source_type;

    typedef struct packed
    {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] ready;
        logic started;
        logic [2:0] req_src;
        logic [3:0] req_div;
        logic [2:0] cur_src;
        logic [3:0] cur_div;
        logic [9:0] cur_ratio;
        logic hold;
        logic new_ready;
        logic [7:0] force_on;
        logic [7:0] osc_en;
        logic int_status;
        logic int_mask;
        logic irq;
        logic [31:0] rdata;
    } css_state_type;
endpackage : css_pkg

// ### test_clock_switch_status_control.sv
// Self-checking bench of the clock switch status and control block
`timescale 1ns/100ps
`include "css_map.svh"
module test_clock_switch_status_control;
    import css_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] rst_src;
    logic [3:0] rst_div;
    logic ext_rdy, hf_rdy, mf_rdy, lf_rdy, frc_rdy, pll_lock;
    css_source_type sys_src;
    logic [3:0] sys_div;
    logic [9:0] sys_ratio;
    logic ext_en, hf_en, mf_en, lf_en, frc_en, pll_en, irq, use_pll;
    int err_total, checks_done;
    logic [7:0] bad [5] = '{8'h43, 8'h33, 8'h03, 8'h5A, 8'h5F};
    // Every source code at least once and every divider code once
    logic [7:0] req [10] = '{8'h60, 8'h71, 8'h22, 8'h13, 8'h54, 8'h65, 8'h76, 8'h27, 8'h18, 8'h69};

    css_clock_switch dut_u
    (
        .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .RESET_SOURCE(rst_src), .RESET_DIVIDER(rst_div),
        .EXT_READY(ext_rdy), .HF_READY(hf_rdy), .MF_READY(mf_rdy), .LF_READY(lf_rdy),
        .FRC_READY(frc_rdy), .PLL_LOCK(pll_lock), .SYS_SOURCE(sys_src),
        .SYS_DIVIDER(sys_div), .SYS_DIV_RATIO(sys_ratio), .EXT_ENABLE(ext_en),
        .HF_ENABLE(hf_en), .MF_ENABLE(mf_en), .LF_ENABLE(lf_en), .FRC_ENABLE(frc_en),
        .PLL_ENABLE(pll_en), .IRQ(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // =====================================================
    // Report and compare
    task automatic close_out;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chk1(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : chk1

    // =====================================================
    // APB master
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            err_total++;
            close_out();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, {24'h0, e});
    endtask : rc

    // Look a little after the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // =====================================================
    // Sequence
    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rst_src = 3'b101;
        rst_div = 4'h3;
        {ext_rdy, hf_rdy, mf_rdy, lf_rdy, frc_rdy, pll_lock} = 6'b011110;
        err_total = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rc(`CSS_OFF_CURRENT, 8'h53);
        rc(`CSS_OFF_REQUEST, 8'h53);
        rc(`CSS_OFF_SWITCH, 8'h10);
        chk1(serr, 1'b0);
        chk({29'h0, sys_src}, {29'h0, CSS_SRC_LF});
        wr(`CSS_OFF_FORCE, 8'hFF);
        rc(`CSS_OFF_FORCE, 8'hF4);
        chk1(mf_en, 1'b1);
        chk1(ext_en, 1'b1);
        chk1(hf_en, 1'b1);
        chk1(lf_en, 1'b1);
        chk1(frc_en, 1'b1);
        rc(`CSS_OFF_READY, 8'h74);
        ext_rdy <= 1'b1;
        pll_lock <= 1'b1;
        settle(6);
        rc(`CSS_OFF_READY, 8'hF4);
        wr(`CSS_OFF_CURRENT, 8'h61);
        rc(`CSS_OFF_CURRENT, 8'h53);
        foreach (bad[i])
        begin
            wr(`CSS_OFF_REQUEST, bad[i]);
            rc(`CSS_OFF_REQUEST, 8'h53);
        end
        rc(`CSS_OFF_CURRENT, 8'h53);
        // Held switch raises the interrupt but keeps the old clock
        wr(`CSS_OFF_INT_MASK, 8'h01);
        wr(`CSS_OFF_SWITCH, 8'h80);
        wr(`CSS_OFF_REQUEST, 8'h61);
        settle(4);
        rc(`CSS_OFF_SWITCH, 8'h88);
        chk1(irq, 1'b1);
        rc(`CSS_OFF_INT_STATUS, 8'h01);
        rc(`CSS_OFF_CURRENT, 8'h53);
        wr(`CSS_OFF_SWITCH, 8'h00);
        settle(3);
        rc(`CSS_OFF_CURRENT, 8'h61);
        rc(`CSS_OFF_SWITCH, 8'h10);
        wr(`CSS_OFF_INT_STATUS, 8'h01);
        settle(2);
        chk1(irq, 1'b0);
        rc(`CSS_OFF_INT_STATUS, 8'h00);
        wr(`CSS_OFF_INT_MASK, 8'h00);
        foreach (req[i])
        begin
            use_pll = req[i][6:4] == 3'b010 || req[i][6:4] == 3'b001;
            wr(`CSS_OFF_REQUEST, req[i]);
            settle(10);
            rc(`CSS_OFF_CURRENT, req[i]);
            chk({22'h0, sys_ratio}, 32'h1 << req[i][3:0]);
            chk({28'h0, sys_div}, {28'h0, req[i][3:0]});
            rc(`CSS_OFF_SWITCH, 8'h10);
            rc(`CSS_OFF_READY, use_pll ? 8'hF5 : 8'hF4);
            chk1(pll_en, use_pll);
            chk1(irq, 1'b0);
        end
        rc(`CSS_OFF_INT_STATUS, 8'h01);
        // Unready target leaves the switch pending, then it is abandoned
        lf_rdy <= 1'b0;
        settle(6);
        wr(`CSS_OFF_REQUEST, 8'h50);
        settle(6);
        rc(`CSS_OFF_SWITCH, 8'h00);
        rc(`CSS_OFF_CURRENT, 8'h69);
        wr(`CSS_OFF_REQUEST, 8'h69);
        settle(3);
        rc(`CSS_OFF_SWITCH, 8'h10);
        xfer(1'b0, 8'h1C, 32'h0);
        chk(rdat, 32'h0);
        chk1(serr, 1'b1);
        wr(`CSS_OFF_FORCE, 8'h00);
        settle(2);
        chk1(mf_en, 1'b0);
        close_out();
    end
endmodule : test_clock_switch_status_control
